// >>> hw/pbeio_pkg.sv
/*
  Package for the port B / port E I/O block: register offsets, assignment-register
  field positions, per-mode reset values and the operating-mode enumeration.
  Assumes the chip's mode logic supplies the mode as pbeio_mode_t.
*/
package pbeio_pkg;

  // ===========================================================================
  // Register offsets
  localparam logic [7:0] OFF_PORT_B_DATA = 8'h01;
  localparam logic [7:0] OFF_PORT_B_DIR = 8'h03;
  localparam logic [7:0] OFF_PORT_E_DATA = 8'h08;
  localparam logic [7:0] OFF_PORT_E_DIR = 8'h09;
  localparam logic [7:0] OFF_PORT_E_ASSIGN = 8'h0a;

  // ===========================================================================
  // Assignment register field positions
  localparam int unsigned BIT_NO_DBE = 7;
  localparam int unsigned BIT_CGM_TEST = 6;
  localparam int unsigned BIT_QSTAT_OE = 5;
  localparam int unsigned BIT_NO_EXTERNAL_BUS_CLOCK = 4;
  localparam int unsigned BIT_LOW_BYTE_STROBE_EN = 3;
  localparam int unsigned BIT_RDWR_EN = 2;
  localparam int unsigned BIT_CAL_EN = 1;
  localparam int unsigned BIT_DBE_EXTERNAL_BUS_CLOCK_SEL = 0;

  // Port E pins that can never drive (interrupt inputs)
  localparam logic [7:0] PE_INPUT_ONLY = 8'h03;

  // Bits written once in normal modes, anytime but the first in special modes
  localparam logic [7:0] ASSIGN_ONCE_MASK = 8'h2d;
  // Bits writable at any time
  localparam logic [7:0] ASSIGN_FREE_MASK = 8'h02;

  // ===========================================================================
  // Assignment register reset values by mode
  localparam logic [7:0] RST_NORM_EXP = 8'h00;
  localparam logic [7:0] RST_SPEC_EXP = 8'h2c;
  localparam logic [7:0] RST_PERIPH = 8'hd0;
  localparam logic [7:0] RST_NORM_SC = 8'h90;
  localparam logic [7:0] RST_SPEC_SC = 8'h2c;

  // Direction and data reset values
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  typedef enum logic [2:0] {
    MODE_NORM_SC,
    MODE_NORM_EXP_WIDE,
    MODE_NORM_EXP_NARROW,
    MODE_SPEC_SC,
    MODE_SPEC_EXP_WIDE,
    MODE_SPEC_EXP_NARROW,
    MODE_PERIPH
  } pbeio_mode_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pbeio_req_t;

  // Alternate-function signals offered to port E by the bus controller
  typedef struct packed {
    logic dataBusEnable;
    logic externalBusClock;
    logic calRef;
    logic queueStatus1;
    logic queueStatus0;
    logic clockGenTestOut;
    logic lowByteStrobe;
    logic readWrite;
  } pbeio_alt_t;

endpackage

// >>> hw/pbeio_reg8.sv
/*
  One 8-bit storage register with synchronous reset and write enable; read data
  come out of the register itself.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module pbeio_reg8 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reset value and write port
  input wire logic [7:0] rstVal,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  // Stored value
  output logic [7:0] value
);

  // ===========================================================================
  // Storage
  // Reset value is a constant at every instance, so only constants reach the reset path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value <= rstVal;
    end else if (wrEn) begin
      value <= wrData;
    end
  end

endmodule

// >>> hw/pbeio_top.sv
/*
  Port B and port E general-purpose I/O with the port E assignment register.
  Assumes the chip supplies the operating mode and emulation bit as levels steady
  around reset, and drives the external bus side (address/data, bus-control
  signals) from its bus controller; pads resolve from the output enables.
*/
// Strobed register access was decided locally.
`timescale 1ns/1ps

// Operation
// [R01] Expanded wide/peripheral: port B muxes low address and data; narrow: address only. Code drives only data in peripheral mode.
// [R02] Without external addressing, port B pins are GPIO steered by direction.
// [R03] Expanded and peripheral modes remove port B data/direction from the map.
// [R04] Direction bit 0 gives input, 1 gives output; registers read/write anytime.
// [R05] Port E bits 1 and 0 never drive and always read the pin.
// [R06] Port E data/direction absent in peripheral, or expanded with emulation set.
// [R07] Assignment bit selects alternate function, overriding the pin's direction bit.
// [R08] Assignment reset value depends on mode per the reset table.
// [R09] Normal single chip: all port E pins reset as GPIO.
// [R10] Normal expanded: only data-bus-enable and bus clock default to alternates.
// [R11] Software enables further bus-control signals before accesses that need them.
// [R12] Special expanded: bus-control signals enabled from reset.
// [R13] Peripheral: assignment register inaccessible; clock test enable resets to one.
// [R14] No-data-bus-enable: write once normal, special anytime but first; readable.
// [R15] No-data-bus-enable 0: bit 7 bus enable/clock; 1: calibration or GPIO.
// [R16] Single chip/peripheral: no-data-bus-enable ignored; bit 7 calibration or GPIO.
// [R17] Clock test enable never writable normal; special anytime but first write.
// [R18] Clock test enable puts test signal on bit 6; queue status overrides. Code does so only in special expanded and peripheral modes.
// [R19] One control bit enables pull-ups on listed port E pins when inputs.
// [R20] Port E alternate functions are assigned per bit as listed.
// [R21] Emulation bit in expanded mode makes port E registers external accesses.
// [R22] Queue status enable drives bits 6 and 5 with queue status in expanded modes.
// [R23] Calibration enable places reference on bit 7 in the allowed conditions.
// [R24] Data read returns pin for inputs, latch for outputs; writes update latch.
module pbeio_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode control
  input wire pbeio_pkg::pbeio_mode_t mode,
  input wire logic portEEmulation,
  input wire logic pullUpEnableE,
  // Register port
  input wire pbeio_pkg::pbeio_req_t req,
  output logic [7:0] rdData,
  output logic rdHit,
  // External bus side for port B
  input wire logic [7:0] busAddrLow,
  input wire logic [7:0] busDataLow,
  input wire logic busDataPhase,
  input wire logic busDataDrive,
  // Alternate functions offered to port E
  input wire pbeio_pkg::pbeio_alt_t alt,
  // Port B pads
  input wire logic [7:0] portBIn,
  output logic [7:0] portBOut,
  output logic [7:0] portBOe_n,
  // Port E pads
  input wire logic [7:0] portEIn,
  output logic [7:0] portEOut,
  output logic [7:0] portEOe_n,
  output logic [7:0] portEPullUp
);

  // ===========================================================================
  // Mode decoding
  function automatic logic isExpanded(input pbeio_pkg::pbeio_mode_t m);
    isExpanded = (m == pbeio_pkg::MODE_NORM_EXP_WIDE) || (m == pbeio_pkg::MODE_NORM_EXP_NARROW)
      || (m == pbeio_pkg::MODE_SPEC_EXP_WIDE) || (m == pbeio_pkg::MODE_SPEC_EXP_NARROW);
  endfunction

  function automatic logic isSpecial(input pbeio_pkg::pbeio_mode_t m);
    isSpecial = (m == pbeio_pkg::MODE_SPEC_SC) || (m == pbeio_pkg::MODE_SPEC_EXP_WIDE)
      || (m == pbeio_pkg::MODE_SPEC_EXP_NARROW);
  endfunction

  function automatic logic isNarrow(input pbeio_pkg::pbeio_mode_t m);
    isNarrow = (m == pbeio_pkg::MODE_NORM_EXP_NARROW) || (m == pbeio_pkg::MODE_SPEC_EXP_NARROW);
  endfunction

  logic expanded;
  logic special;
  logic periph;
  logic singleChip;
  logic normExp;
  assign expanded = isExpanded(mode);
  assign special = isSpecial(mode);
  assign periph = (mode == pbeio_pkg::MODE_PERIPH);
  assign singleChip = !expanded && !periph;
  assign normExp = expanded && !special;

  // ===========================================================================
  // Map visibility
  logic portBMapped;
  logic portEMapped;
  logic assignMapped;
  assign portBMapped = singleChip; // [R03]
  assign portEMapped = !periph && !(expanded && portEEmulation); // [R06] [R21]
  assign assignMapped = !periph; // [R13]

  logic wrPbData;
  logic wrPbDir;
  logic wrPeData;
  logic wrPeDir;
  logic wrAssign;
  assign wrPbData = req.wr && portBMapped && (req.addr == pbeio_pkg::OFF_PORT_B_DATA);
  assign wrPbDir = req.wr && portBMapped && (req.addr == pbeio_pkg::OFF_PORT_B_DIR);
  assign wrPeData = req.wr && portEMapped && (req.addr == pbeio_pkg::OFF_PORT_E_DATA);
  assign wrPeDir = req.wr && portEMapped && (req.addr == pbeio_pkg::OFF_PORT_E_DIR);
  assign wrAssign = req.wr && assignMapped && (req.addr == pbeio_pkg::OFF_PORT_E_ASSIGN);

  // ===========================================================================
  // Data and direction registers
  logic [7:0] pbLatch;
  logic [7:0] pbDir;
  logic [7:0] peLatch;
  logic [7:0] peDirRaw;
  logic [7:0] peDir;

  // Latches and directions are plain storage, writable whenever mapped
  pbeio_reg8 uPbData (.clk(clk), .rst_n(rst_n), .rstVal(pbeio_pkg::RST_DATA),
    .wrEn(wrPbData), .wrData(req.wdata), .value(pbLatch)); // [R04] [R24]
  pbeio_reg8 uPbDir (.clk(clk), .rst_n(rst_n), .rstVal(pbeio_pkg::RST_DIR),
    .wrEn(wrPbDir), .wrData(req.wdata), .value(pbDir)); // [R04]
  pbeio_reg8 uPeData (.clk(clk), .rst_n(rst_n), .rstVal(pbeio_pkg::RST_DATA),
    .wrEn(wrPeData), .wrData(req.wdata), .value(peLatch)); // [R24]
  pbeio_reg8 uPeDir (.clk(clk), .rst_n(rst_n), .rstVal(pbeio_pkg::RST_DIR),
    .wrEn(wrPeDir), .wrData(req.wdata), .value(peDirRaw));

  // Interrupt pins are held as inputs whatever software stores
  assign peDir = peDirRaw & ~pbeio_pkg::PE_INPUT_ONLY; // [R05]

  // ===========================================================================
  // Assignment register
  function automatic logic [7:0] assignReset(input pbeio_pkg::pbeio_mode_t m);
    case (m)
      pbeio_pkg::MODE_NORM_EXP_WIDE: assignReset = pbeio_pkg::RST_NORM_EXP;
      pbeio_pkg::MODE_NORM_EXP_NARROW: assignReset = pbeio_pkg::RST_NORM_EXP;
      pbeio_pkg::MODE_SPEC_EXP_WIDE: assignReset = pbeio_pkg::RST_SPEC_EXP;
      pbeio_pkg::MODE_SPEC_EXP_NARROW: assignReset = pbeio_pkg::RST_SPEC_EXP;
      pbeio_pkg::MODE_PERIPH: assignReset = pbeio_pkg::RST_PERIPH;
      pbeio_pkg::MODE_SPEC_SC: assignReset = pbeio_pkg::RST_SPEC_SC;
      default: assignReset = pbeio_pkg::RST_NORM_SC;
    endcase
  endfunction

  logic [7:0] assign_q;
  logic firstWriteDone_q;
  logic [7:0] assignMask;
  logic modeCaught_q;

  // Which bits a write may change, given write history and mode
  always_comb begin
    assignMask = pbeio_pkg::ASSIGN_FREE_MASK;
    if (special) begin
      if (firstWriteDone_q) begin
        assignMask = assignMask | pbeio_pkg::ASSIGN_ONCE_MASK; // [R14]
        assignMask[pbeio_pkg::BIT_NO_DBE] = 1'b1; // [R14]
        assignMask[pbeio_pkg::BIT_CGM_TEST] = 1'b1; // [R17]
      end
    end else if (!firstWriteDone_q) begin
      assignMask = assignMask | pbeio_pkg::ASSIGN_ONCE_MASK;
      assignMask[pbeio_pkg::BIT_NO_DBE] = 1'b1; // [R14]
      assignMask[pbeio_pkg::BIT_NO_EXTERNAL_BUS_CLOCK] = (mode == pbeio_pkg::MODE_NORM_SC);
    end
  end

  // Mode-dependent reset value is loaded right after release, since reset takes constants
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      assign_q <= pbeio_pkg::RST_NORM_EXP;
      modeCaught_q <= 1'b0;
    end else if (!modeCaught_q) begin
      assign_q <= assignReset(mode); // [R08] [R09] [R10] [R12] [R13]
      modeCaught_q <= 1'b1;
    end else if (wrAssign) begin
      assign_q <= (assign_q & ~assignMask) | (req.wdata & assignMask);
    end
  end

  // Tracks the first write, which special modes ignore for once-bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      firstWriteDone_q <= 1'b0;
    end else if (wrAssign && modeCaught_q) begin
      firstWriteDone_q <= 1'b1;
    end
  end

  // ===========================================================================
  // Port E pin function selection
  logic [7:0] peAltSel;
  logic [7:0] peAltVal;
  logic [7:0] peAltOe;

  always_comb begin
    peAltSel = 8'h00;
    peAltVal = 8'h00;
    peAltOe = 8'h00;
    // Bit 7: bus enable / inverted clock, else calibration, else GPIO
    if (expanded && !assign_q[pbeio_pkg::BIT_NO_DBE]) begin
      peAltSel[7] = 1'b1; // [R15]
      peAltOe[7] = 1'b1;
      peAltVal[7] = assign_q[pbeio_pkg::BIT_DBE_EXTERNAL_BUS_CLOCK_SEL] ? !alt.externalBusClock
        : alt.dataBusEnable; // [R20]
    end else if (assign_q[pbeio_pkg::BIT_CAL_EN]) begin
      peAltSel[7] = 1'b1; // [R16] [R23]
      peAltOe[7] = 1'b1;
      peAltVal[7] = alt.calRef;
    end
    // Bits 6 and 5: queue status overrides the clock test output
    if (expanded && assign_q[pbeio_pkg::BIT_QSTAT_OE]) begin
      peAltSel[6:5] = 2'b11; // [R22]
      peAltOe[6:5] = 2'b11;
      peAltVal[6] = alt.queueStatus1;
      peAltVal[5] = alt.queueStatus0;
    end else if (assign_q[pbeio_pkg::BIT_CGM_TEST] && !singleChip && !normExp) begin
      peAltSel[6] = 1'b1; // [R18]
      peAltOe[6] = 1'b1;
      peAltVal[6] = alt.clockGenTestOut;
    end
    // Bit 4: bus clock; an input in peripheral mode
    if (!assign_q[pbeio_pkg::BIT_NO_EXTERNAL_BUS_CLOCK]) begin
      peAltSel[4] = 1'b1; // [R20]
      peAltOe[4] = !periph;
      peAltVal[4] = alt.externalBusClock;
    end
    // Bit 3: strobe, not in single chip or normal narrow
    if (assign_q[pbeio_pkg::BIT_LOW_BYTE_STROBE_EN] && !singleChip
        && !(normExp && isNarrow(mode))) begin
      peAltSel[3] = 1'b1; // [R07]
      peAltOe[3] = 1'b1;
      peAltVal[3] = alt.lowByteStrobe;
    end
    // Bit 2: read/write, not in single chip
    if (assign_q[pbeio_pkg::BIT_RDWR_EN] && !singleChip) begin
      peAltSel[2] = 1'b1; // [R07]
      peAltOe[2] = 1'b1;
      peAltVal[2] = alt.readWrite;
    end
  end

  // ===========================================================================
  // Port E pads
  logic [7:0] peDrive;
  assign peDrive = (peAltSel & peAltOe) | (~peAltSel & peDir); // [R07]

  // Pads are registered so every output leaves a flip-flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portEOut <= 8'h00;
      portEOe_n <= 8'hff;
    end else begin
      portEOut <= (peAltSel & peAltVal) | (~peAltSel & peLatch);
      portEOe_n <= ~(peDrive & ~pbeio_pkg::PE_INPUT_ONLY); // [R05]
    end
  end

  // Pull-ups on bits 7, 3..0 only while those pins are inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portEPullUp <= 8'h00;
    end else begin
      portEPullUp <= {8{pullUpEnableE}} & 8'h8f & ~peDrive; // [R19]
    end
  end

  // ===========================================================================
  // Port B pads: GPIO in single chip, address/data otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portBOut <= 8'h00;
      portBOe_n <= 8'hff;
    end else if (portBMapped) begin
      portBOut <= pbLatch; // [R02]
      portBOe_n <= ~pbDir; // [R04]
    end else if (periph) begin
      portBOut <= busDataLow;
      portBOe_n <= (busDataPhase && busDataDrive) ? 8'h00 : 8'hff; // [R01]
    end else if (isNarrow(mode) || !busDataPhase) begin
      portBOut <= busAddrLow; // [R01]
      portBOe_n <= 8'h00;
    end else begin
      portBOut <= busDataLow; // [R01]
      portBOe_n <= busDataDrive ? 8'h00 : 8'hff;
    end
  end

  // ===========================================================================
  // Register reads; data stand one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData <= 8'h00;
      rdHit <= 1'b0;
    end else begin
      rdData <= 8'h00;
      rdHit <= 1'b0;
      if (req.rd) begin
        if (portBMapped && req.addr == pbeio_pkg::OFF_PORT_B_DATA) begin
          rdData <= (pbDir & pbLatch) | (~pbDir & portBIn); // [R24]
          rdHit <= 1'b1;
        end else if (portBMapped && req.addr == pbeio_pkg::OFF_PORT_B_DIR) begin
          rdData <= pbDir;
          rdHit <= 1'b1;
        end else if (portEMapped && req.addr == pbeio_pkg::OFF_PORT_E_DATA) begin
          rdData <= (peDir & peLatch) | (~peDir & portEIn); // [R05] [R24]
          rdHit <= 1'b1;
        end else if (portEMapped && req.addr == pbeio_pkg::OFF_PORT_E_DIR) begin
          rdData <= peDir;
          rdHit <= 1'b1;
        end else if (assignMapped && req.addr == pbeio_pkg::OFF_PORT_E_ASSIGN) begin
          rdData <= assign_q;
          rdHit <= 1'b1;
        end
      end
    end
  end

  // ===========================================================================
  // Checks
  AST_PE_IRQ_NEVER_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    portEOe_n[1:0] == 2'b11) else $error("interrupt pin driven"); // [R05]

  AST_PB_GPIO_DIR: assert property (@(posedge clk) disable iff (!rst_n)
    portBMapped && $stable(portBMapped) |=> portBOe_n == ~$past(pbDir))
    else $error("port B direction not applied"); // [R04]

  AST_PB_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && !portBMapped && req.addr == pbeio_pkg::OFF_PORT_B_DATA |=> !rdHit)
    else $error("port B visible in expanded mode"); // [R03]

  AST_PE_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && (periph || (expanded && portEEmulation))
    && req.addr == pbeio_pkg::OFF_PORT_E_DIR |=> !rdHit)
    else $error("port E registers visible"); // [R06]

  AST_ASSIGN_RESET: assert property (@(posedge clk)
    !rst_n ##1 rst_n |=> assign_q == assignReset($past(mode)))
    else $error("assignment reset value wrong"); // [R08]

  AST_CGM_NORMAL_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    modeCaught_q && !special |=> assign_q[pbeio_pkg::BIT_CGM_TEST]
    == $past(assign_q[pbeio_pkg::BIT_CGM_TEST]))
    else $error("clock test enable changed in normal mode"); // [R17]

  AST_SPECIAL_FIRST_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    modeCaught_q && special && !firstWriteDone_q && wrAssign
    |=> assign_q[pbeio_pkg::BIT_NO_DBE] == $past(assign_q[pbeio_pkg::BIT_NO_DBE]))
    else $error("first special write changed once-bit"); // [R14]

  AST_PE_READ_INPUT: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && portEMapped && req.addr == pbeio_pkg::OFF_PORT_E_DATA
    |=> rdHit && rdData[1:0] == $past(portEIn[1:0]))
    else $error("interrupt pin level not readable"); // [R24]

  AST_QSTAT_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_n)
    expanded && assign_q[pbeio_pkg::BIT_QSTAT_OE] |=> portEOut[6] == $past(alt.queueStatus1))
    else $error("queue status not on bit 6"); // [R22]

endmodule

// >>> tb/pbeio_ext_model.sv
/*
  Far-side model of the port B / port E pads: external parts that drive the pins
  when the device releases them, plus pull-ups and floating lines.
  Assumes the bench sets which pins the outside world drives and with what.
*/
`timescale 1ns/1ps
module pbeio_ext_model (
  // Clock
  input wire logic clk,
  // Device pad outputs
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOe_n,
  input wire logic [7:0] portEOut,
  input wire logic [7:0] portEOe_n,
  input wire logic [7:0] portEPullUp,
  // Outside drivers
  input wire logic [7:0] extBVal,
  input wire logic [7:0] extBEn,
  input wire logic [7:0] extEVal,
  input wire logic [7:0] extEEn,
  // Resolved pin levels
  output logic [7:0] portBIn,
  output logic [7:0] portEIn
);
  // ===========================================================================
  // Floating lines toggle every cycle so a read of an undriven pin never looks stable
  logic [7:0] floatQ = 8'h5a;

  always @(posedge clk) begin
    floatQ <= ~floatQ;
  end

  // Device wins, then outside driver, then pull-up on port E only, else float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      portBIn[i] = !portBOe_n[i] ? portBOut[i] : (extBEn[i] ? extBVal[i] : floatQ[i]);
      portEIn[i] = !portEOe_n[i] ? portEOut[i] : (extEEn[i] ? extEVal[i] :
                   (portEPullUp[i] ? 1'b1 : floatQ[i]));
    end
  end
endmodule

// >>> tb/test_port_b_e_io_and_pin_assignment.sv
/*
  Self-checking bench for the port B / port E block: a per-mode reset table, then
  hand-written cases for GPIO, bus multiplexing and assignment-register locking.
  Assumes the pad model in pbeio_ext_model and registered pad outputs.
*/
`timescale 1ns/1ps
module test_port_b_e_io_and_pin_assignment;
  typedef struct packed {
    pbeio_pkg::pbeio_mode_t m;
    logic port_e_emulation;
    logic [7:0] asg;
    logic hitB;
    logic hitE;
    logic hitA;
  } pbeio_row_t;

  // ===========================================================================
  // Stimulus and observed signals
  localparam int CYCLE_LIMIT = 5000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pbeio_pkg::pbeio_mode_t mode = pbeio_pkg::MODE_NORM_SC;
  logic portEEmulation = 1'b0;
  logic pullUpEnableE = 1'b0;
  pbeio_pkg::pbeio_req_t req = '0;
  logic [7:0] busAddrLow = 8'h00;
  logic [7:0] busDataLow = 8'h00;
  logic busDataPhase = 1'b0;
  logic busDataDrive = 1'b0;
  pbeio_pkg::pbeio_alt_t alt = '0;
  logic [7:0] extBVal = 8'h00;
  logic [7:0] extBEn = 8'h00;
  logic [7:0] extEVal = 8'h00;
  logic [7:0] extEEn = 8'h00;
  logic [7:0] rdData, portBIn, portBOut, portBOe_n, portEIn, portEOut, portEOe_n, portEPullUp;
  logic rdHit;
  logic [7:0] rv;
  logic rdHitSeen;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  // Mode, emulation, assignment reset value, then which registers answer
  pbeio_row_t rows [7] = '{
    '{pbeio_pkg::MODE_NORM_SC, 1'b0, 8'h90, 1'b1, 1'b1, 1'b1},
    '{pbeio_pkg::MODE_NORM_EXP_WIDE, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1},
    '{pbeio_pkg::MODE_NORM_EXP_NARROW, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1},
    '{pbeio_pkg::MODE_SPEC_SC, 1'b0, 8'h2c, 1'b1, 1'b1, 1'b1},
    '{pbeio_pkg::MODE_SPEC_EXP_WIDE, 1'b0, 8'h2c, 1'b0, 1'b1, 1'b1},
    '{pbeio_pkg::MODE_SPEC_EXP_NARROW, 1'b0, 8'h2c, 1'b0, 1'b1, 1'b1},
    '{pbeio_pkg::MODE_PERIPH, 1'b0, 8'hd0, 1'b0, 1'b0, 1'b0}};

  // Clock
  always #5 clk = ~clk;

  // ===========================================================================
  // Design and pad model
  pbeio_top u_dut (.clk(clk), .rst_n(rst_n), .mode(mode), .portEEmulation(portEEmulation),
    .pullUpEnableE(pullUpEnableE), .req(req), .rdData(rdData), .rdHit(rdHit),
    .busAddrLow(busAddrLow), .busDataLow(busDataLow), .busDataPhase(busDataPhase),
    .busDataDrive(busDataDrive), .alt(alt), .portBIn(portBIn), .portBOut(portBOut),
    .portBOe_n(portBOe_n), .portEIn(portEIn), .portEOut(portEOut), .portEOe_n(portEOe_n),
    .portEPullUp(portEPullUp));
  pbeio_ext_model u_ext (.clk(clk), .portBOut(portBOut), .portBOe_n(portBOe_n),
    .portEOut(portEOut), .portEOe_n(portEOe_n), .portEPullUp(portEPullUp),
    .extBVal(extBVal), .extBEn(extBEn), .extEVal(extEVal), .extEEn(extEEn),
    .portBIn(portBIn), .portEIn(portEIn));

  // ===========================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    rv = rdData;
    rdHitSeen = rdHit;
    chk(n, rv, e);
    chk({n, "_hit"}, {7'h0, rdHitSeen}, {7'h0, h});
  endtask

  // Pads are registered, so give them a few edges to follow
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Mode held steady through reset; returns at the second edge after release, so the first request is driven at the third
  task automatic reset_in(input pbeio_pkg::pbeio_mode_t m, input logic e, input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    mode <= m;
    portEEmulation <= e;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic wrap_up;
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard: a run far past the expected length counts as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  // ===========================================================================
  // Main sequence
  initial begin
    reset_in(pbeio_pkg::MODE_NORM_SC, 1'b0, 16);
    foreach (rows[i]) begin
      reset_in(rows[i].m, rows[i].port_e_emulation, 2);
      rdchk("assign_rst", pbeio_pkg::OFF_PORT_E_ASSIGN, rows[i].hitA ? rows[i].asg : 8'h00,
        rows[i].hitA);
      rdchk("pb_dir_map", pbeio_pkg::OFF_PORT_B_DIR, 8'h00, rows[i].hitB);
      rdchk("pe_dir_map", pbeio_pkg::OFF_PORT_E_DIR, 8'h00, rows[i].hitE);
    end
    // Peripheral mode: clock test output on bit 6 straight from reset
    alt.clockGenTestOut <= 1'b1;
    settle;
    chk("pe6_periph", {6'h0, portEOe_n[6], portEOut[6]}, 8'h01);
    chk("pb_periph_idle", portBOe_n, 8'hff);
    // Normal single chip: port B and port E as plain I/O
    reset_in(pbeio_pkg::MODE_NORM_SC, 1'b0, 2);
    wr(pbeio_pkg::OFF_PORT_B_DIR, 8'hf0);
    wr(pbeio_pkg::OFF_PORT_B_DATA, 8'ha5);
    extBVal <= 8'h3c;
    extBEn <= 8'h0f;
    settle;
    chk("pb_oe", portBOe_n, 8'h0f);
    chk("pb_out", {portBOut[7:4], 4'h0}, 8'ha0);
    rdchk("pb_data", pbeio_pkg::OFF_PORT_B_DATA, 8'hac, 1'b1);
    rdchk("pb_dir", pbeio_pkg::OFF_PORT_B_DIR, 8'hf0, 1'b1);
    rdchk("unmapped", 8'h05, 8'h00, 1'b0);
    wr(pbeio_pkg::OFF_PORT_E_DIR, 8'hff);
    wr(pbeio_pkg::OFF_PORT_E_DATA, 8'hff);
    extEVal <= 8'h02;
    extEEn <= 8'h03;
    pullUpEnableE <= 1'b1;
    settle;
    chk("pe_oe_sc", portEOe_n, 8'h03);
    rdchk("pe_data", pbeio_pkg::OFF_PORT_E_DATA, 8'hfe, 1'b1);
    chk("pe_pull_out", portEPullUp, 8'h03);
    wr(pbeio_pkg::OFF_PORT_E_DIR, 8'h00);
    settle;
    chk("pe_pull_in", portEPullUp, 8'h8f);
    // Normal expanded: bus enable and bus clock override direction; port B multiplexed
    reset_in(pbeio_pkg::MODE_NORM_EXP_WIDE, 1'b0, 2);
    alt <= '{dataBusEnable: 1'b1, externalBusClock: 1'b1, default: 1'b0};
    busAddrLow <= 8'h5a;
    busDataLow <= 8'hc3;
    busDataDrive <= 1'b1;
    settle;
    chk("pe_oe_exp", portEOe_n, 8'h6f);
    chk("pe_alt_out", portEOut & 8'h90, 8'h90);
    chk("pb_addr", portBOut, 8'h5a);
    busDataPhase <= 1'b1;
    settle;
    chk("pb_data_ph", portBOut, 8'hc3);
    // Software turns on strobe and read/write before any external write
    wr(pbeio_pkg::OFF_PORT_E_ASSIGN, 8'hff);
    settle;
    chk("pe_strobe_rw", portEOe_n & 8'h0c, 8'h00);
    rdchk("assign_once", pbeio_pkg::OFF_PORT_E_ASSIGN, 8'haf, 1'b1);
    wr(pbeio_pkg::OFF_PORT_E_ASSIGN, 8'h00);
    rdchk("assign_lock", pbeio_pkg::OFF_PORT_E_ASSIGN, 8'had, 1'b1);
    reset_in(pbeio_pkg::MODE_NORM_EXP_NARROW, 1'b0, 2);
    // Data phase still high, so only a narrow port keeps the address byte out
    settle;
    chk("pb_narrow", portBOut, 8'h5a);
    // Special expanded: first write takes only the calibration bit, later writes all bits but bit 4
    reset_in(pbeio_pkg::MODE_SPEC_EXP_WIDE, 1'b0, 2);
    alt <= '{clockGenTestOut: 1'b1, queueStatus1: 1'b1, calRef: 1'b1, default: 1'b0};
    wr(pbeio_pkg::OFF_PORT_E_ASSIGN, 8'hff);
    rdchk("assign_first", pbeio_pkg::OFF_PORT_E_ASSIGN, 8'h2e, 1'b1);
    wr(pbeio_pkg::OFF_PORT_E_ASSIGN, 8'hc1);
    rdchk("assign_free", pbeio_pkg::OFF_PORT_E_ASSIGN, 8'hc1, 1'b1);
    settle;
    chk("pe6_test", {6'h0, portEOe_n[6], portEOut[6]}, 8'h01);
    chk("pe7_gpio", {7'h0, portEOe_n[7]}, 8'h01);
    wr(pbeio_pkg::OFF_PORT_E_ASSIGN, 8'hc3);
    settle;
    chk("pe7_cal", {6'h0, portEOe_n[7], portEOut[7]}, 8'h01);
    alt.clockGenTestOut <= 1'b0;
    wr(pbeio_pkg::OFF_PORT_E_ASSIGN, 8'he1);
    settle;
    chk("pe65_queue", {4'h0, portEOe_n[6:5], portEOut[6:5]}, 8'h02);
    // Special single chip: bit 7 stays plain I/O although no-data-bus-enable resets clear
    reset_in(pbeio_pkg::MODE_SPEC_SC, 1'b0, 2);
    settle;
    chk("pe7_sc", {7'h0, portEOe_n[7]}, 8'h01);
    wrap_up();
  end
endmodule
